/* File: common/codec_cfg_pkg.sv */
// shared constants, types and register layout for the codec mode/clock configuration link
// assumes both ends run on one core clock; frame/bit clocks cross as sampled levels
package codec_cfg_pkg;
  localparam int SAMPLE_W = 24;
  localparam int TIMEOUT_FRAMES = 1045;
  localparam int MUTE_FRAMES = 8192;
  localparam int BCLK_PER_FRAME = 64;
  localparam logic [7:0] REG_MODE = 8'h03;
  localparam logic [7:0] REG_IFACE = 8'h04;
  localparam logic [7:0] REG_POWER = 8'h02;
  localparam logic [7:0] REG_MUTE = 8'h06;
  localparam int POWER_DOWN_BIT = 0;
  localparam int FM_LSB = 4;
  localparam int RATIO_LSB = 1;
  localparam int LOOPBACK_BIT = 5;
  localparam int PLAY_FMT_LSB = 3;
  localparam int REC_FMT_BIT = 0;
  localparam int AUTOMUTE_BIT = 5;
  localparam logic [7:0] MUTE_RESET = 8'h20;
  localparam logic [1:0] FM_SLAVE = 2'h3;
  // apb offsets of the controller
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam logic [11:0] APB_WADDR = 12'h008;
  localparam logic [11:0] APB_WDATA = 12'h00C;
  typedef enum logic [1:0] {
    SPD_SINGLE = 2'b00,
    SPD_DOUBLE = 2'b01,
    SPD_QUAD = 2'b10
  } speed_t;
  typedef enum logic [1:0] {
    OPM_WAIT = 2'b00,
    OPM_STANDALONE = 2'b01,
    OPM_CONTROL = 2'b10
  } opmode_t;
  // mclk/frame ratio per speed and ratio code; 0 marks an illegal code
  function automatic logic [10:0] mclk_ratio(input speed_t s, input logic [2:0] code);
    logic [10:0] base;
    base = 11'h000;
    unique case (code)
      3'h0: base = 11'h100;
      3'h1: base = 11'h180;
      3'h2: base = 11'h200;
      3'h3: base = 11'h300;
      3'h4: base = 11'h400;
      default: base = 11'h000;
    endcase
    unique case (s)
      SPD_DOUBLE: mclk_ratio = base >> 1;
      SPD_QUAD: mclk_ratio = base >> 2;
      default: mclk_ratio = base;
    endcase
  endfunction : mclk_ratio
endpackage : codec_cfg_pkg

/* File: common/codec_link_if.sv */
// link between the codec end and the host end: strap pins, register write port,
// frame/bit clocks (two-way) and per-channel audio samples
`timescale 1ns/1ns
`default_nettype none
interface codec_link_if;
  import codec_cfg_pkg::*;
  logic speed_sel_hi;
  logic speed_sel_lo;
  logic format_select_pin;
  logic master_strap;
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_data;
  logic frame_clock_dev;
  logic frame_clock_dev_oe;
  logic bit_clock_dev;
  logic bit_clock_dev_oe;
  logic frame_clock_host;
  logic bit_clock_host;
  logic frame_clock;
  logic bit_clock;
  logic sample_valid;
  logic [SAMPLE_W-1:0] play_left;
  logic [SAMPLE_W-1:0] play_right;
  logic record_data_out;
  assign frame_clock = frame_clock_dev_oe ? frame_clock_dev : frame_clock_host;
  assign bit_clock = bit_clock_dev_oe ? bit_clock_dev : bit_clock_host;
  modport device (
    input speed_sel_hi, speed_sel_lo, format_select_pin, master_strap,
    input reg_wr, reg_addr, reg_data, frame_clock, bit_clock,
    input sample_valid, play_left, play_right,
    output frame_clock_dev, frame_clock_dev_oe, bit_clock_dev, bit_clock_dev_oe,
    output record_data_out
  );
  modport host (
    output speed_sel_hi, speed_sel_lo, format_select_pin, master_strap,
    output reg_wr, reg_addr, reg_data, frame_clock_host, bit_clock_host,
    output sample_valid, play_left, play_right,
    input frame_clock, bit_clock, record_data_out
  );
endinterface : codec_link_if
`default_nettype wire

/* File: rtl/codec_device.sv */
// codec end: mode entry, stand-alone strap decode, master clock generation,
// loopback format handling and per-channel auto-mute
// assumes straps stable through reset and frame/bit clocks from the link asynchronous
`timescale 1ns/1ns
`default_nettype none
module codec_device
  import codec_cfg_pkg::*;
#(
  parameter int TIMEOUT_N = TIMEOUT_FRAMES,
  parameter int MUTE_N = MUTE_FRAMES
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  codec_link_if.device link,
  input wire logic [SAMPLE_W-1:0] rec_left_i,
  input wire logic [SAMPLE_W-1:0] rec_right_i,
  output logic [SAMPLE_W-1:0] dac_left_o,
  output logic [SAMPLE_W-1:0] dac_right_o,
  output logic [1:0] mute_ctrl_o,
  output logic hpf_enable_o,
  output logic deemph_o,
  output logic i2s_play_o,
  output logic i2s_rec_o,
  output logic running_o,
  output logic master_o,
  output speed_t speed_o,
  output logic [10:0] mclk_ratio_o
);
  import codec_cfg_pkg::*;
  // both frame counters are 16 bits wide
  if (TIMEOUT_N < 1 || TIMEOUT_N > 65535 || MUTE_N < 1 || MUTE_N > 65535) begin : g_bad_count
    $error("codec_device: count parameter out of range");
  end
  typedef struct packed {
    logic [1:0] fsync;
    logic [1:0] bsync;
    logic fr_prev;
    logic br_prev;
    opmode_t opm;
    logic strap_done;
    logic straps_hi;
    logic straps_lo;
    logic straps_fmt;
    logic straps_master;
    logic [15:0] tmo;
    logic [7:0] r_power;
    logic [7:0] r_mode;
    logic [7:0] r_iface;
    logic [7:0] r_mute;
    logic [1:0] play_fmt_eff;
    logic [7:0] bits_per_frame;
    logic [7:0] bit_cnt;
    logic [7:0] meas_bits;
    logic [10:0] div_cnt;
    logic [5:0] bclk_idx;
    logic fr_out;
    logic br_out;
    logic [1:0][15:0] static_cnt;
    logic [1:0] muted;
    logic [1:0][SAMPLE_W-1:0] dac;
  } state_t;
  state_t s_reg, s_next;
  logic f_rise, b_rise, master, sa;
  logic [1:0][SAMPLE_W-1:0] play_in;
  speed_t spd;
  logic [10:0] ratio, half_bclk;
  always_comb begin
    sa = (s_reg.opm == OPM_STANDALONE);
    master = sa ? s_reg.straps_master : (s_reg.r_mode[FM_LSB +: 2] != FM_SLAVE);
    f_rise = s_reg.fsync[1] & ~s_reg.fr_prev;
    b_rise = s_reg.bsync[1] & ~s_reg.br_prev;
    // slave speed from bit clocks per frame class: >=96 single
    if (sa && master) begin
      spd = s_reg.straps_hi ? (s_reg.straps_lo ? SPD_QUAD : SPD_DOUBLE) : SPD_SINGLE;
    end else if (sa) begin
      spd = (s_reg.meas_bits >= 8'h60) ? SPD_SINGLE : SPD_DOUBLE;
    end else begin
      spd = speed_t'(s_reg.r_mode[FM_LSB +: 2] == 2'h2 ? SPD_QUAD :
            (s_reg.r_mode[FM_LSB +: 2] == 2'h1 ? SPD_DOUBLE : SPD_SINGLE));
    end
    ratio = mclk_ratio(spd, sa ? {1'b0, s_reg.straps_hi, s_reg.straps_lo} :
                       s_reg.r_mode[RATIO_LSB +: 3]);
    // ratios below 128 leave no room for a 64x bit clock: the divider then toggles every cycle
    half_bclk = (ratio >> 7); // mclk cycles per half bit clock at 64 bits/frame
    play_in[0] = link.play_left;
    play_in[1] = link.play_right;
    if (s_reg.r_iface[LOOPBACK_BIT] && !sa) begin
      play_in[0] = rec_left_i;
      play_in[1] = rec_right_i;
    end
  end
  always_comb begin
    s_next = s_reg;
    s_next.fsync = {s_reg.fsync[0], link.frame_clock};
    s_next.bsync = {s_reg.bsync[0], link.bit_clock};
    s_next.fr_prev = s_reg.fsync[1];
    s_next.br_prev = s_reg.bsync[1];
    if (!s_reg.strap_done) begin
      s_next.strap_done = 1'b1;
      s_next.straps_hi = link.speed_sel_hi;
      s_next.straps_lo = link.speed_sel_lo;
      s_next.straps_fmt = link.format_select_pin;
      s_next.straps_master = link.master_strap;
    end
    if (link.reg_wr) begin
      unique case (link.reg_addr)
        REG_POWER: s_next.r_power = link.reg_data;
        REG_MODE: s_next.r_mode = link.reg_data;
        REG_IFACE: s_next.r_iface = link.reg_data;
        REG_MUTE: s_next.r_mute = link.reg_data;
        default: ;
      endcase
      if (s_reg.opm == OPM_WAIT && link.reg_addr == REG_POWER && link.reg_data[POWER_DOWN_BIT]) begin
        s_next.opm = OPM_CONTROL;
      end
    end
    // a power-down write landing on the last frame still wins over the timeout
    if (s_next.opm == OPM_WAIT && f_rise) begin
      s_next.tmo = s_reg.tmo + 16'h0001;
      if (s_reg.tmo == 16'(TIMEOUT_N - 1)) begin
        s_next.opm = OPM_STANDALONE;
      end
    end
    if (!s_next.r_iface[LOOPBACK_BIT]) begin
      s_next.play_fmt_eff = s_next.r_iface[PLAY_FMT_LSB +: 2];
    end
    // slave bit-clock count per frame, used for auto speed detect
    if (b_rise) begin
      s_next.bit_cnt = s_reg.bit_cnt + 8'h01;
    end
    if (f_rise) begin
      s_next.meas_bits = s_reg.bit_cnt;
      s_next.bit_cnt = 8'h00;
    end
    // master clock generation from the core clock used as master clock
    if (master && s_reg.opm != OPM_WAIT) begin
      if (s_reg.div_cnt + 11'h001 >= half_bclk) begin
        s_next.div_cnt = 11'h000;
        s_next.br_out = ~s_reg.br_out;
        if (s_reg.br_out) begin
          s_next.bclk_idx = s_reg.bclk_idx + 6'h01;
          if (s_reg.bclk_idx == 6'h1F || s_reg.bclk_idx == 6'h3F) begin
            s_next.fr_out = ~s_reg.fr_out;
          end
        end
      end else begin
        s_next.div_cnt = s_reg.div_cnt + 11'h001;
      end
    end
    for (int c = 0; c < 2; c++) begin
      if (link.sample_valid && running_o && f_rise) begin
        s_next.dac[c] = play_in[c];
        if (play_in[c] == '0 || play_in[c] == '1) begin
          if (s_reg.static_cnt[c] != 16'(MUTE_N)) begin
            s_next.static_cnt[c] = s_reg.static_cnt[c] + 16'h0001;
          end
        end else begin
          s_next.static_cnt[c] = 16'h0000;
        end
      end
      // mute enable on from reset; stand-alone always auto-mutes
      s_next.muted[c] = (sa || s_reg.r_mute[AUTOMUTE_BIT]) &&
                        (s_next.static_cnt[c] == 16'(MUTE_N));
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_reg <= '0;
      s_reg.opm <= OPM_WAIT;
      s_reg.r_mode <= {2'b00, FM_SLAVE, 4'h0};
      s_reg.r_mute <= MUTE_RESET;
    end else begin
      s_reg <= s_next;
    end
  end
  assign running_o = sa || (s_reg.opm == OPM_CONTROL && !s_reg.r_power[POWER_DOWN_BIT]);
  assign hpf_enable_o = 1'b1;
  assign master_o = master;
  assign speed_o = spd;
  assign mclk_ratio_o = ratio;
  assign deemph_o = (spd == SPD_SINGLE) && sa && s_reg.straps_lo;
  assign i2s_play_o = sa ? s_reg.straps_fmt : s_reg.play_fmt_eff[0];
  assign i2s_rec_o = sa ? s_reg.straps_fmt : s_reg.r_iface[REC_FMT_BIT];
  // muted channel holds zero code (common mode) and raises its mute output
  assign dac_left_o = s_reg.muted[0] ? '0 : s_reg.dac[0];
  assign dac_right_o = s_reg.muted[1] ? '0 : s_reg.dac[1];
  assign mute_ctrl_o = s_reg.muted;
  assign link.frame_clock_dev = s_reg.fr_out;
  assign link.bit_clock_dev = s_reg.br_out;
  assign link.frame_clock_dev_oe = master && s_reg.opm != OPM_WAIT;
  assign link.bit_clock_dev_oe = master && s_reg.opm != OPM_WAIT;
  assign link.record_data_out = s_reg.dac[0][SAMPLE_W-1];
endmodule : codec_device
`default_nettype wire

/* File: rtl/codec_host.sv */
// host end: drives straps, register writes over apb-controlled port, slave clocks, samples
// assumes the apb master is on core_clk_i
`timescale 1ns/1ns
`default_nettype none
module codec_host
  import codec_cfg_pkg::*;
#(
  parameter int HALF_BCLK = 8
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  codec_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [SAMPLE_W-1:0] samp_left_i,
  input wire logic [SAMPLE_W-1:0] samp_right_i,
  input wire logic samp_valid_i
);
  import codec_cfg_pkg::*;
  // the divider is 8 bits wide
  if (HALF_BCLK < 1 || HALF_BCLK > 255) begin : g_bad_half
    $error("codec_host: HALF_BCLK out of range");
  end
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] waddr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] div;
    logic bclk;
    logic [5:0] bidx;
    logic fclk;
    logic [1:0] rsync;
    logic [31:0] rdata;
  } state_t;
  state_t s_reg, s_next;
  logic acc;
  always_comb begin
    s_next = s_reg;
    s_next.wr = 1'b0;
    s_next.rsync = {s_reg.rsync[0], link.record_data_out};
    acc = psel && penable;
    s_next.rdata = 32'h00000000;
    if (psel && !penable) begin
      unique case (paddr)
        APB_CTRL: s_next.rdata = {24'h000000, s_reg.ctrl};
        APB_STATUS: s_next.rdata = {30'h00000000, link.frame_clock, s_reg.rsync[1]};
        APB_WADDR: s_next.rdata = {24'h000000, s_reg.waddr};
        APB_WDATA: s_next.rdata = {24'h000000, s_reg.wdata};
        default: s_next.rdata = 32'h00000000;
      endcase
    end
    if (acc && pwrite) begin
      unique case (paddr)
        APB_CTRL: s_next.ctrl = pwdata[7:0];
        APB_WADDR: s_next.waddr = pwdata[7:0];
        APB_WDATA: begin
          s_next.wdata = pwdata[7:0];
          s_next.wr = 1'b1;
        end
        default: ;
      endcase
    end
    // slave clocks at 64 bit clocks per frame when ctrl[4] set
    if (s_reg.div == 8'(HALF_BCLK - 1)) begin
      s_next.div = 8'h00;
      s_next.bclk = ~s_reg.bclk;
      if (s_reg.bclk) begin
        s_next.bidx = s_reg.bidx + 6'h01;
        if (s_reg.bidx == 6'h1F || s_reg.bidx == 6'h3F) begin
          s_next.fclk = ~s_reg.fclk;
        end
      end
    end else begin
      s_next.div = s_reg.div + 8'h01;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign prdata = s_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = acc && !(paddr == APB_CTRL || paddr == APB_STATUS ||
                   paddr == APB_WADDR || paddr == APB_WDATA);
  assign link.speed_sel_hi = s_reg.ctrl[0];
  assign link.speed_sel_lo = s_reg.ctrl[1];
  assign link.format_select_pin = s_reg.ctrl[2];
  assign link.master_strap = s_reg.ctrl[3];
  assign link.reg_wr = s_reg.wr;
  assign link.reg_addr = s_reg.waddr;
  assign link.reg_data = s_reg.wdata;
  assign link.frame_clock_host = s_reg.ctrl[4] & s_reg.fclk;
  assign link.bit_clock_host = s_reg.ctrl[4] & s_reg.bclk;
  assign link.sample_valid = samp_valid_i;
  assign link.play_left = samp_left_i;
  assign link.play_right = samp_right_i;
endmodule : codec_host
`default_nettype wire

/* File: tb/codec_link_sva.sv */
// checker on the link wires: device clock making, host clocks and the register port
// assumes one core clock for both ends; srst_i is the codec end's reset
`timescale 1ns/1ns
`default_nettype none
module codec_link_sva
  import codec_cfg_pkg::*;
#(
  parameter int HALF_BCLK = 8
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic master_strap,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_data,
  input wire logic frame_clock_dev,
  input wire logic frame_clock_dev_oe,
  input wire logic bit_clock_dev,
  input wire logic bit_clock_dev_oe,
  input wire logic frame_clock_host,
  input wire logic bit_clock_host
);
  logic bd_q, fd_q, bh_q, fh_q, pdn_q, mode_seen, hv_p;
  logic [1:0] dv_h, dv_f, hv_h;
  logic [7:0] dh_cnt, df_cnt, hh_cnt, hp_cnt;
  wire bd_rise = bit_clock_dev && !bd_q;
  wire fd_edge = frame_clock_dev != fd_q;
  wire fd_rise = frame_clock_dev && !fd_q;
  wire bh_rise = bit_clock_host && !bh_q;
  wire bh_edge = bit_clock_host != bh_q;
  wire fh_edge = frame_clock_host != fh_q;
  wire h_stop = hp_cnt >= 8'(HALF_BCLK);
  always_ff @(posedge core_clk_i) begin
    bd_q <= bit_clock_dev;
    fd_q <= frame_clock_dev;
    bh_q <= bit_clock_host;
    fh_q <= frame_clock_host;
    // a stopped host clock counts as a long gap, so the stray first edge is never timed
    if (srst_i) begin
      hp_cnt <= 8'hFF;
    end else begin
      hp_cnt <= bh_edge ? 8'h00 : (hp_cnt == 8'hFF ? hp_cnt : hp_cnt + 8'h01);
    end
    hh_cnt <= fh_edge ? 8'(bh_rise) : hh_cnt + 8'(bh_rise);
    // the first edge after enable or restart may be a stray one, so two are needed
    if (srst_i || !frame_clock_dev_oe) begin
      dv_h <= 2'h0;
      dv_f <= 2'h0;
      dh_cnt <= 8'h00;
      df_cnt <= 8'h00;
    end else begin
      dh_cnt <= fd_edge ? 8'(bd_rise) : dh_cnt + 8'(bd_rise);
      df_cnt <= fd_rise ? 8'(bd_rise) : df_cnt + 8'(bd_rise);
      if (fd_edge && dv_h != 2'h2) dv_h <= dv_h + 2'h1;
      if (fd_rise && dv_f != 2'h2) dv_f <= dv_f + 2'h1;
    end
    if (srst_i || h_stop) begin
      hv_p <= 1'b0;
      hv_h <= 2'h0;
    end else begin
      if (bh_edge) hv_p <= 1'b1;
      if (fh_edge && hv_h != 2'h2) hv_h <= hv_h + 2'h1;
    end
    if (srst_i) begin
      pdn_q <= 1'b0;
      mode_seen <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == REG_POWER) pdn_q <= reg_data[POWER_DOWN_BIT];
      if (reg_addr == REG_MODE && reg_data[FM_LSB+:2] != FM_SLAVE) mode_seen <= 1'b1;
    end
  end
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  oe_pair_a: assert property (
    frame_clock_dev_oe == bit_clock_dev_oe) else $error("clock enables differ");
  frame_bits_a: assert property (
    fd_rise && dv_f == 2'h2 |-> df_cnt == 8'(BCLK_PER_FRAME)) else $error("bits per frame");
  half_bits_a: assert property (
    fd_edge && dv_h == 2'h2 |-> dh_cnt == 8'h20) else $error("bits per frame half");
  oe_reset_a: assert property (
    $fell(srst_i) |-> !frame_clock_dev_oe && !bit_clock_dev_oe) else $error("drives after reset");
  master_cause_a: assert property (
    $rose(frame_clock_dev_oe) |-> master_strap || mode_seen) else $error("master unasked");
  host_half_a: assert property (
    bh_edge && hv_p |-> hp_cnt == 8'(HALF_BCLK - 1)) else $error("host bit clock period");
  host_frame_a: assert property (
    fh_edge && hv_h == 2'h2 |-> hh_cnt inside {8'h10, 8'h18, 8'h20, 8'h40})
    else $error("host bits per half frame");
  wr_pulse_a: assert property (
    reg_wr |=> !reg_wr) else $error("write strobe too long");
  ratio_pdn_a: assert property (
    reg_wr && reg_addr == REG_MODE |-> pdn_q) else $error("mode write while running");
endmodule : codec_link_sva
`default_nettype wire

/* File: tb/tb_top.sv */
// bench: host end and codec end joined by the link, steered over apb
// assumes a zero-wait apb slave in the host end and shortened frame counts
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import codec_cfg_pkg::*;
  localparam int TO_N = 4;
  localparam int MUTE_N = 8;
  logic core_clk_i = 1'b0;
  logic host_rst = 1'b1;
  logic dev_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, slv;
  logic samp_valid = 1'b0;
  logic [SAMPLE_W-1:0] samp_l = '0, samp_r = '0, rec_l = '0, rec_r = '0, dac_l, dac_r;
  logic [1:0] mute;
  logic hpf, deemph, i2s_play, i2s_rec, running, master;
  speed_t speed;
  logic [10:0] ratio;
  logic [10:0] base_t [5] = '{11'h100, 11'h180, 11'h200, 11'h300, 11'h400};
  int error_cnt = 0;
  int checks_done = 0;
  codec_link_if link_if ();
  always #2 core_clk_i = ~core_clk_i;
  codec_device #(.TIMEOUT_N(TO_N), .MUTE_N(MUTE_N)) u_codec_device (
    .core_clk_i(core_clk_i), .srst_i(dev_rst), .link(link_if),
    .rec_left_i(rec_l), .rec_right_i(rec_r), .dac_left_o(dac_l), .dac_right_o(dac_r),
    .mute_ctrl_o(mute), .hpf_enable_o(hpf), .deemph_o(deemph), .i2s_play_o(i2s_play),
    .i2s_rec_o(i2s_rec), .running_o(running), .master_o(master), .speed_o(speed),
    .mclk_ratio_o(ratio));
  codec_host #(.HALF_BCLK(8)) u_codec_host (
    .core_clk_i(core_clk_i), .srst_i(host_rst), .link(link_if), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .samp_left_i(samp_l), .samp_right_i(samp_r),
    .samp_valid_i(samp_valid));
  codec_link_sva #(.HALF_BCLK(8)) u_codec_link_sva (
    .core_clk_i(core_clk_i), .srst_i(dev_rst), .master_strap(link_if.master_strap),
    .reg_wr(link_if.reg_wr), .reg_addr(link_if.reg_addr), .reg_data(link_if.reg_data),
    .frame_clock_dev(link_if.frame_clock_dev), .frame_clock_dev_oe(link_if.frame_clock_dev_oe),
    .bit_clock_dev(link_if.bit_clock_dev), .bit_clock_dev_oe(link_if.bit_clock_dev_oe),
    .frame_clock_host(link_if.frame_clock_host), .bit_clock_host(link_if.bit_clock_host));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic tmo();
    chk(32'h0, 32'h1);
    end_sim();
  endtask : tmo
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    @(posedge core_clk_i);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 50) tmo();
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // device write goes out as a strobe in the same cycle the data word lands
  task automatic dev_reg(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, APB_WADDR, {24'h0, a});
    apb(1'b1, APB_WDATA, {24'h0, d});
    repeat (4) @(posedge core_clk_i);
  endtask : dev_reg
  // host clocks stay on throughout so frames always exist for the counts
  task automatic straps(input logic hi, input logic lo, input logic fmt, input logic mst);
    apb(1'b1, APB_CTRL, {27'h0, 1'b1, mst, fmt, lo, hi});
    dev_rst <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    dev_rst <= 1'b0;
  endtask : straps
  task automatic wait_frames(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      while (link_if.frame_clock !== 1'b0 && k < 8000) begin
        @(posedge core_clk_i);
        k++;
      end
      while (link_if.frame_clock !== 1'b1 && k < 8000) begin
        @(posedge core_clk_i);
        k++;
      end
      if (k >= 8000) tmo();
    end
  endtask : wait_frames
  initial begin
    repeat (2) @(posedge core_clk_i);
    host_rst <= 1'b0;
    dev_rst <= 1'b0;
    @(posedge core_clk_i);
    chk(hpf, 1);
    apb(1'b0, 12'h010, 32'h0);
    chk(slv, 1);
    chk(rd, 0);
    $display("test reset done");
    straps(1'b0, 1'b1, 1'b1, 1'b0);
    wait_frames(TO_N - 2);
    chk(running, 0);
    wait_frames(5);
    chk(master, 0);
    chk(speed, SPD_DOUBLE);
    chk(deemph, 0);
    chk(i2s_play, 1);
    chk(i2s_rec, 1);
    chk(hpf, 1);
    apb(1'b1, APB_CTRL, 32'h12);
    apb(1'b0, APB_CTRL, 32'h0);
    chk(rd, 32'h12);
    chk(slv, 0);
    wait_frames(1);
    chk(i2s_play, 1);
    $display("test slave stand-alone done");
    for (int i = 0; i < 4; i++) begin
      straps(i[1], i[0], i[0], 1'b1);
      wait_frames(TO_N + 3);
      chk(master, 1);
      chk(speed, (i < 2) ? 0 : i - 1);
      chk(deemph, 32'(i == 1));
      chk(i2s_play, i[0]);
    end
    $display("test master stand-alone done");
    straps(1'b0, 1'b0, 1'b0, 1'b0);
    dev_reg(REG_POWER, 8'h01);
    wait_frames(TO_N + 2);
    chk(running, 0);
    chk(master, 0);
    for (int s = 0; s < 3; s++) begin
      for (int c = 0; c < 5; c++) begin
        dev_reg(REG_MODE, {2'b00, 2'(s), 3'(c), 1'b0});
        chk(ratio, base_t[c] >> s);
        chk(speed, s);
      end
    end
    dev_reg(REG_MODE, 8'h00);
    dev_reg(REG_POWER, 8'h00);
    wait_frames(2);
    chk(running, 1);
    chk(master, 1);
    chk(link_if.bit_clock_dev_oe, 1);
    $display("test control mode done");
    samp_valid <= 1'b1;
    for (int i = 0; i < MUTE_N + 4; i++) begin
      if (i == MUTE_N / 2) chk(mute, 2'b00);
      samp_r <= 24'h000100 + 24'(i);
      wait_frames(1);
    end
    chk(mute, 2'b01);
    chk(dac_l, 0);
    samp_l <= '1;
    samp_r <= '1;
    wait_frames(MUTE_N + 4);
    chk(mute, 2'b11);
    chk(dac_l, 0);
    samp_l <= 24'h000123;
    wait_frames(3);
    chk(mute, 2'b10);
    samp_r <= 24'h000456;
    wait_frames(3);
    chk(mute, 2'b00);
    $display("test auto-mute done");
    rec_l <= 24'h0ABCDE;
    rec_r <= 24'h012345;
    dev_reg(REG_IFACE, 8'h08);
    chk(i2s_play, 1);
    chk(i2s_rec, 0);
    dev_reg(REG_IFACE, 8'h21);
    chk(i2s_play, 1);
    chk(i2s_rec, 1);
    wait_frames(3);
    chk(dac_l, rec_l);
    chk(dac_r, rec_r);
    dev_reg(REG_IFACE, 8'h01);
    chk(i2s_play, 0);
    $display("test loopback done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
